//--- hw/cap_policy.sv
// cache attribute decode and policy selection with an axi4-lite register slave
//
// Overview of operation
// - split attribute into write-allocate, read-allocate, cacheable, bufferable; pick policy.
// - cacheable with no allocate bits is outer noncacheable, bufferable ignored.
// - cacheable read hit returns level two data, no level three access.
// - read-allocate read miss starts a linefill allocating the line.
// - cacheable read miss without read-allocate goes to level three, no allocation.
// - write-back write hit enters store buffer, updates level two, marks dirty.
// - write-through write hit enters store buffer, updates level two and three.
// - write-allocate miss buffered; partial entry fetched, then allocated; write-through writes three.
// - shared override, forced write-allocate and exclusive setting alter the mapping.
// - every legal attribute combination is accepted and handled, except cacheable ones on fixed bursts, which give CAP_UNDEF.
// - bufferable-only writes enter store buffer unmerged and drain immediately.
// - outer noncacheable reads bypass level two unless shared and not overridden; writes drain via store buffer.
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "cap_defines.svh"

module cap_policy
    import cap_pkg::*;
(
    input  wire logic        aclk,          // 250 MHz clock
    input  wire logic        aresetn,       // synchronous reset, active low
    // transaction presented for a policy decision
    input  wire logic        txn_valid,     // attribute below is valid this cycle
    input  wire logic        txn_write,     // 1 write, 0 read
    input  wire logic [3:0]  txn_cache,     // four-bit cache attribute
    input  wire logic [1:0]  txn_burst,     // burst type
    input  wire logic        txn_shared,    // shared attribute
    input  wire logic        txn_hit,       // lookup hit in level two
    input  wire logic        txn_full,      // store buffer entry fully written
    // decision
    output logic             pol_valid,     // decision valid, one-cycle pulse
    output cap_action_type   pol_action,    // chosen action
    output logic             pol_lookup,    // level two lookup used
    output logic             pol_l2_write,  // level two line updated
    output logic             pol_l3_access, // level three accessed
    output logic             pol_allocate,  // line allocated into level two
    output logic             pol_fetch,     // word or line fetched from level three
    output logic             pol_dirty,     // line marked dirty
    output logic             pol_buffer,    // enters store buffer
    output logic             pol_merge_ok,  // buffer entry may merge
    output logic             pol_drain_now, // drain immediately
    output logic             pol_invalidate,// exclusive read hit invalidates line
    // axi4-lite slave
    input  wire logic [3:0]  s_awaddr,      // write address
    input  wire logic        s_awvalid,     // write address valid
    output logic             s_awready,     // write address ready
    input  wire logic [31:0] s_wdata,       // write data
    input  wire logic [3:0]  s_wstrb,       // write strobes
    input  wire logic        s_wvalid,      // write data valid
    output logic             s_wready,      // write data ready
    output logic [1:0]       s_bresp,       // write response
    output logic             s_bvalid,      // write response valid
    input  wire logic        s_bready,      // write response ready
    input  wire logic [3:0]  s_araddr,      // read address
    input  wire logic        s_arvalid,     // read address valid
    output logic             s_arready,     // read address ready
    output logic [31:0]      s_rdata,       // read data
    output logic [1:0]       s_rresp,       // read response
    output logic             s_rvalid,      // read response valid
    input  wire logic        s_rready       // read response ready
);

    // ----------------------------------------------------------------
    // attribute decode
    // ----------------------------------------------------------------
    logic [31:0] ctrl;
    logic [31:0] last_decision;
    logic [15:0] count_txn;
    logic [15:0] count_undef;

    wire [1:0] fwa_mode    = ctrl[`CAP_CTRL_FWA_LSB +: 2];
    wire       excl_en     = ctrl[`CAP_CTRL_EXCL];
    wire       shared_ovr  = ctrl[`CAP_CTRL_SAOE];
    wire       write_allocate_hint_in = txn_cache[`CAP_WR_ALLOC_BIT];
    wire       read_allocate_hint     = txn_cache[`CAP_RD_ALLOC_BIT];
    wire       cacheable_in           = txn_cache[`CAP_C_BIT];
    wire       bufferable             = txn_cache[`CAP_B_BIT];

    // outer noncacheable; bufferable bit does not matter here
    wire       outer_nc = cacheable_in && !write_allocate_hint_in
                          && !read_allocate_hint;
    // shared noncacheable turns into cacheable no allocate unless overridden
    wire       shared_nc = outer_nc && txn_shared && !shared_ovr;
    wire       cacheable = cacheable_in && (!outer_nc || shared_nc);
    wire       write_back = bufferable && !shared_nc;
    // shared signal wins over forced allocation, which wins over the attribute's write-allocate bit
    wire       write_allocate_hint =
        txn_shared ? 1'b0 :
        (fwa_mode == `CAP_FWA_NEVER)  ? 1'b0 :
        (fwa_mode == `CAP_FWA_ALWAYS) ? cacheable :
        write_allocate_hint_in;
    wire       excl_type = excl_en && cacheable && write_back
                           && (read_allocate_hint || write_allocate_hint_in);
    wire       illegal   = cacheable_in && (txn_burst == `CAP_BURST_FIXED);

    // ----------------------------------------------------------------
    // policy selection
    // ----------------------------------------------------------------
    cap_action_type next_action;
    always_comb begin
        if (illegal) begin
            next_action = CAP_UNDEF;
        end else if (!cacheable_in && !bufferable) begin
            next_action = CAP_SO_L3;
        end else if (!cacheable_in) begin
            next_action = txn_write ? CAP_SB_L3_NOW : CAP_L3_READ;
        end else if (!cacheable) begin
            next_action = txn_write ? CAP_SB_L3 : CAP_L3_READ;
        end else if (!txn_write) begin
            if (txn_hit) begin
                next_action = CAP_L2_READ;
            end else if (read_allocate_hint && !excl_type) begin
                next_action = CAP_LINEFILL;
            end else begin
                next_action = CAP_L3_READ;
            end
        end else if (txn_hit) begin
            next_action = write_back ? CAP_SB_L2_DIRTY : CAP_SB_L2_L3;
        end else if (write_allocate_hint) begin
            next_action = write_back ? CAP_SB_ALLOC : CAP_SB_ALLOC_L3;
        end else begin
            next_action = CAP_SB_L3;
        end
    end

    // ----------------------------------------------------------------
    // action effects
    // ----------------------------------------------------------------
    wire act_alloc = (next_action == CAP_SB_ALLOC) || (next_action == CAP_SB_ALLOC_L3);
    wire next_lookup   = cacheable && !illegal;
    wire next_l2_write = (next_action == CAP_SB_L2_DIRTY) || (next_action == CAP_SB_L2_L3)
                         || act_alloc;
    wire next_l3 = (next_action == CAP_LINEFILL) || (next_action == CAP_L3_READ)
                   || (next_action == CAP_SB_L2_L3) || (next_action == CAP_SB_ALLOC_L3)
                   || (next_action == CAP_SB_L3) || (next_action == CAP_SB_L3_NOW)
                   || (next_action == CAP_SO_L3)
                   || ((next_action == CAP_SB_ALLOC) && !txn_full);
    wire next_alloc = (next_action == CAP_LINEFILL) || act_alloc;
    wire next_fetch = act_alloc && !txn_full;
    wire next_dirty = (next_action == CAP_SB_L2_DIRTY) || (next_action == CAP_SB_ALLOC);
    wire next_buffer = txn_write && (next_action != CAP_SO_L3)
                       && (next_action != CAP_UNDEF);
    wire next_merge  = next_buffer && (next_action != CAP_SB_L3_NOW);
    wire next_drain  = (next_action == CAP_SB_L3_NOW);
    wire next_inval  = excl_type && !txn_write && txn_hit;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pol_valid      <= 1'b0;
            pol_action     <= CAP_SO_L3;
            pol_lookup     <= 1'b0;
            pol_l2_write   <= 1'b0;
            pol_l3_access  <= 1'b0;
            pol_allocate   <= 1'b0;
            pol_fetch      <= 1'b0;
            pol_dirty      <= 1'b0;
            pol_buffer     <= 1'b0;
            pol_merge_ok   <= 1'b0;
            pol_drain_now  <= 1'b0;
            pol_invalidate <= 1'b0;
        end else begin
            pol_valid      <= txn_valid;
            pol_action     <= next_action;
            pol_lookup     <= txn_valid && next_lookup;
            pol_l2_write   <= txn_valid && next_l2_write;
            pol_l3_access  <= txn_valid && next_l3;
            pol_allocate   <= txn_valid && next_alloc;
            pol_fetch      <= txn_valid && next_fetch;
            pol_dirty      <= txn_valid && next_dirty;
            pol_buffer     <= txn_valid && next_buffer;
            pol_merge_ok   <= txn_valid && next_merge;
            pol_drain_now  <= txn_valid && next_drain;
            pol_invalidate <= txn_valid && next_inval;
        end
    end

    // ----------------------------------------------------------------
    // statistics
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_decision <= 32'h0000_0000;
            count_txn     <= 16'h0000;
            count_undef   <= 16'h0000;
        end else if (txn_valid) begin
            last_decision <= {20'h00000, txn_write, txn_hit, txn_full, illegal,
                              4'(next_action), txn_cache};
            count_txn     <= count_txn + 16'h0001;
            count_undef   <= count_undef + {15'h0000, illegal};
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    logic       aw_held;
    logic       w_held;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    wire aw_take  = s_awvalid && s_awready;
    wire w_take   = s_wvalid && s_wready;
    wire have_aw  = aw_held || aw_take;
    wire have_w   = w_held || w_take;
    wire [3:0]  wr_addr = aw_held ? aw_addr : s_awaddr;
    wire [31:0] wr_data = w_held ? w_data : s_wdata;
    wire [3:0]  wr_strb = w_held ? w_strb : s_wstrb;
    wire wr_fire  = have_aw && have_w && !s_bvalid;
    wire wr_ctrl  = wr_fire && (wr_addr == `CAP_ADDR_CTRL);
    wire wr_ok    = (wr_addr == `CAP_ADDR_CTRL) || (wr_addr == `CAP_ADDR_STATUS)
                    || (wr_addr == `CAP_ADDR_LAST) || (wr_addr == `CAP_ADDR_COUNT);
    wire [31:0] strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire [31:0] next_ctrl = (ctrl & ~strb_mask) | (wr_data & strb_mask & 32'h0000_000f);

    wire ar_take  = s_arvalid && s_arready;
    wire [31:0] rd_mux =
        (s_araddr == `CAP_ADDR_CTRL)   ? ctrl :
        (s_araddr == `CAP_ADDR_STATUS) ? {16'h0000, count_undef} :
        (s_araddr == `CAP_ADDR_LAST)   ? last_decision :
        (s_araddr == `CAP_ADDR_COUNT)  ? {16'h0000, count_txn} : 32'h0000_0000;
    wire rd_ok = (s_araddr == `CAP_ADDR_CTRL) || (s_araddr == `CAP_ADDR_STATUS)
                 || (s_araddr == `CAP_ADDR_LAST) || (s_araddr == `CAP_ADDR_COUNT);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr   <= 4'h0;
            w_data    <= 32'h0000_0000;
            w_strb    <= 4'h0;
            s_bvalid  <= 1'b0;
            s_bresp   <= `CAP_RESP_OKAY;
            ctrl      <= `CAP_CTRL_RESET;
        end else begin
            s_awready <= !have_aw && !s_bvalid;
            s_wready  <= !have_w && !s_bvalid;
            if (aw_take) begin
                aw_addr <= s_awaddr;
            end
            if (w_take) begin
                w_data <= s_wdata;
                w_strb <= s_wstrb;
            end
            aw_held <= have_aw && !wr_fire;
            w_held  <= have_w && !wr_fire;
            if (wr_fire) begin
                s_bvalid <= 1'b1;
                s_bresp  <= wr_ok ? `CAP_RESP_OKAY : `CAP_RESP_SLVERR;
            end else if (s_bready) begin
                s_bvalid <= 1'b0;
            end
            if (wr_ctrl) begin
                ctrl <= next_ctrl;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0000_0000;
            s_rresp   <= `CAP_RESP_OKAY;
        end else begin
            s_arready <= !s_rvalid && !ar_take;
            if (ar_take) begin
                s_rvalid <= 1'b1;
                s_rdata  <= rd_mux;
                s_rresp  <= rd_ok ? `CAP_RESP_OKAY : `CAP_RESP_SLVERR;
            end else if (s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

endmodule

//--- hw/cap_defines.svh
// constants for the cache attribute policy block
`ifndef CAP_DEFINES_SVH
`define CAP_DEFINES_SVH
`define CAP_WR_ALLOC_BIT  3
`define CAP_RD_ALLOC_BIT  2
`define CAP_C_BIT         1
`define CAP_B_BIT         0
`define CAP_FWA_USE       2'h0
`define CAP_FWA_NEVER     2'h1
`define CAP_FWA_ALWAYS    2'h2
`define CAP_ADDR_CTRL     4'h0
`define CAP_ADDR_STATUS   4'h4
`define CAP_ADDR_LAST     4'h8
`define CAP_ADDR_COUNT    4'hc
`define CAP_CTRL_FWA_LSB  0
`define CAP_CTRL_EXCL     2
`define CAP_CTRL_SAOE     3
`define CAP_CTRL_RESET    32'h0000_0000
`define CAP_RESP_OKAY     2'h0
`define CAP_RESP_SLVERR   2'h2
`define CAP_BURST_FIXED   2'h0
`endif

//--- hw/cap_pkg.sv
// types shared by the cache attribute policy block
package cap_pkg;
    typedef enum logic [3:0] {
        CAP_L2_READ,      // read from level two
        CAP_LINEFILL,     // read miss, allocate line
        CAP_L3_READ,      // read miss, no allocation
        CAP_SB_L2_DIRTY,  // store buffer, level two, mark dirty
        CAP_SB_L2_L3,     // store buffer, level two and three
        CAP_SB_ALLOC,     // store buffer, fetch then allocate
        CAP_SB_ALLOC_L3,  // allocate and write level three
        CAP_SB_L3,        // store buffer, level three on drain
        CAP_SB_L3_NOW,    // store buffer, no merge, drain now
        CAP_SO_L3,        // strongly ordered, straight to level three
        CAP_UNDEF         // cacheable fixed burst, no defined result
    } cap_action_type;
endpackage

//--- test/cap_policy_assertions.sv
// checker for the cache attribute policy block
`timescale 1ns/1ps
module cap_policy_assertions
    import cap_pkg::*;
(
    input wire logic           aclk,          // clock
    input wire logic           aresetn,       // reset, active low
    input wire logic           txn_valid,     // request
    input wire logic           txn_write,     // write
    input wire logic [3:0]     txn_cache,     // attribute
    input wire logic [1:0]     txn_burst,     // burst type
    input wire logic           txn_hit,       // lookup hit
    input wire logic           pol_valid,     // decision valid
    input wire cap_action_type pol_action,    // action
    input wire logic           pol_l3_access, // level three used
    input wire logic           pol_allocate,  // allocation
    input wire logic           pol_dirty,     // dirty mark
    input wire logic           pol_buffer,    // store buffer
    input wire logic           pol_merge_ok,  // merge allowed
    input wire logic           pol_drain_now  // immediate drain
);
    logic go;
    logic alloc_c;
    assign go = txn_valid && txn_burst != 2'h0;
    assign alloc_c = txn_cache[1] && (txn_cache[3] || txn_cache[2]);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    resp_pulse_a: assert property (txn_valid |=> pol_valid)
        else $error("no decision after request");
    quiet_idle_a: assert property (!txn_valid |=> !pol_valid && !pol_buffer && !pol_l3_access)
        else $error("decision without request");
    read_hit_a: assert property (go && !txn_write && txn_hit && alloc_c
        |=> pol_action == CAP_L2_READ && !pol_l3_access) else $error("read hit went to l3");
    line_fill_a: assert property (go && !txn_write && !txn_hit && alloc_c && txn_cache[2]
        && !txn_cache[0] |=> pol_allocate && pol_l3_access) else $error("no linefill");
    no_alloc_read_a: assert property (go && !txn_write && !txn_hit && txn_cache[1]
        && !txn_cache[2] |=> !pol_allocate && pol_l3_access) else $error("bad read miss");
    wb_hit_a: assert property (go && txn_write && txn_hit && alloc_c && txn_cache[0]
        |=> pol_dirty && pol_buffer && !pol_l3_access) else $error("bad write-back hit");
    wt_hit_a: assert property (go && txn_write && txn_hit && alloc_c && !txn_cache[0]
        |=> pol_l3_access && pol_buffer && !pol_dirty) else $error("bad write-through hit");
    strong_order_a: assert property (txn_valid && txn_cache == 4'h0
        |=> pol_action == CAP_SO_L3 && !pol_buffer && !pol_allocate) else $error("bad ordered");
    device_write_a: assert property (txn_valid && txn_write && txn_cache == 4'h1
        |=> pol_buffer && pol_drain_now && !pol_merge_ok) else $error("bad device write");
    cover property (go && !txn_write && !txn_hit && txn_cache[2]);
    cover property (go && txn_write && !txn_hit && txn_cache[3]);
    cover property (txn_valid && txn_write && txn_cache == 4'h1);
endmodule

//--- test/cap_master_model.sv
// model of the transaction source facing the policy block
`timescale 1ns/1ps
module cap_master_model (
    input  wire logic  aclk,       // clock
    output logic       txn_valid,  // request
    output logic       txn_write,  // write
    output logic [3:0] txn_cache,  // attribute
    output logic [1:0] txn_burst,  // burst type
    output logic       txn_shared, // shared
    output logic       txn_hit,    // lookup hit
    output logic       txn_full    // entry full
);
    initial begin
        txn_valid = 1'b0;
        txn_write = 1'b0;
        txn_cache = 4'h0;
        txn_burst = 2'h1;
        txn_shared = 1'b0;
        txn_hit = 1'b0;
        txn_full = 1'b0;
    end
    task automatic issue(input logic w, input logic [3:0] c, input logic h, input logic f);
        @(posedge aclk);
        txn_valid <= 1'b1;
        txn_write <= w;
        txn_cache <= c;
        txn_burst <= 2'h1; // incrementing bursts only
        txn_hit <= h;
        txn_full <= f;
        @(posedge aclk);
        txn_valid <= 1'b0;
        txn_write <= ~w;
        txn_cache <= ~c;
        txn_hit <= ~h;
    endtask
    task automatic set_shared(input logic s);
        @(posedge aclk);
        txn_shared <= s;
    endtask
endmodule

//--- test/testbench.sv
// self-checking bench for the cache attribute policy block
`timescale 1ns/1ps
module testbench
    import cap_pkg::*;
;
    logic aclk, aresetn, txn_valid, txn_write, txn_shared, txn_hit, txn_full;
    logic [3:0] txn_cache, s_awaddr, s_wstrb, s_araddr;
    logic [1:0] txn_burst, s_bresp, s_rresp, resp;
    logic pol_valid, pol_lookup, pol_l2_write, pol_l3_access, pol_allocate, pol_fetch;
    logic pol_dirty, pol_buffer, pol_merge_ok, pol_drain_now, pol_invalidate;
    cap_action_type pol_action;
    logic [31:0] s_wdata, s_rdata, rd;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready;
    logic [9:0] seen;
    logic [2:0] extra;
    int failures, checks_done;
    logic [3:0] legal [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'ha, 4'hb, 4'he, 4'hf};
    initial aclk = 1'b0;
    always #2 aclk = ~aclk;
    cap_policy cap_policy_i (.aclk, .aresetn, .txn_valid, .txn_write, .txn_cache, .txn_burst,
        .txn_shared, .txn_hit, .txn_full, .pol_valid, .pol_action, .pol_lookup, .pol_l2_write,
        .pol_l3_access, .pol_allocate, .pol_fetch, .pol_dirty, .pol_buffer, .pol_merge_ok,
        .pol_drain_now, .pol_invalidate, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
        .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
        .s_rdata, .s_rresp, .s_rvalid, .s_rready);
    cap_master_model cap_master_model_i (.aclk, .txn_valid, .txn_write, .txn_cache, .txn_burst,
        .txn_shared, .txn_hit, .txn_full);
    //--------------------------------------------------------------
    // shared tasks
    //--------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // waits for the answer however long it takes; only the watchdog ends a hang
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_awvalid && s_awready) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready) s_wvalid <= 1'b0;
            if (s_bvalid) begin
                resp = s_bresp;
                s_bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    task automatic axi_read(input logic [3:0] a);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_arvalid && s_arready) s_arvalid <= 1'b0;
            if (s_rvalid) begin
                resp = s_rresp;
                rd = s_rdata;
                s_rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    task automatic txn(input logic w, input logic [3:0] c, input logic h, input logic f);
        cap_master_model_i.issue(w, c, h, f);
        #1;
        seen = {pol_action, pol_l3_access, pol_allocate, pol_fetch, pol_buffer, pol_dirty,
            pol_valid};
        extra = {pol_lookup, pol_l2_write, pol_invalidate};
    endtask
    function automatic cap_action_type exp_act(logic w, logic [3:0] c, logic h);
        if (!c[1]) return !c[0] ? CAP_SO_L3 : (w ? CAP_SB_L3_NOW : CAP_L3_READ);
        if (c[3:2] == 2'h0) return w ? CAP_SB_L3 : CAP_L3_READ;
        if (!w) return h ? CAP_L2_READ : (c[2] ? CAP_LINEFILL : CAP_L3_READ);
        if (h) return c[0] ? CAP_SB_L2_DIRTY : CAP_SB_L2_L3;
        if (!c[3]) return CAP_SB_L3;
        return c[0] ? CAP_SB_ALLOC : CAP_SB_ALLOC_L3;
    endfunction
    function automatic logic [9:0] exp_vec(logic w, logic [3:0] c, logic h, logic f);
        cap_action_type a;
        logic al;
        a = exp_act(w, c, h);
        al = a inside {CAP_LINEFILL, CAP_SB_ALLOC, CAP_SB_ALLOC_L3};
        return {a, !(a inside {CAP_L2_READ, CAP_SB_L2_DIRTY} || (a == CAP_SB_ALLOC && f)), al,
            al && w && !f, w && a != CAP_SO_L3, a inside {CAP_SB_L2_DIRTY, CAP_SB_ALLOC}, 1'b1};
    endfunction
    //--------------------------------------------------------------
    // scenarios
    //--------------------------------------------------------------
    task automatic test_regs;
        axi_read(4'h0);
        check({30'h0, resp}, 32'h0, "ctrl reset resp");
        check(rd, 32'h0, "ctrl reset value");
        axi_write(4'h0, 32'h1);
        axi_read(4'h0);
        check(rd, 32'h1, "ctrl readback");
        txn(1'b1, 4'hf, 1'b0, 1'b0);
        check({22'h0, seen}, {22'h0, exp_vec(1'b1, 4'h7, 1'b0, 1'b0)}, "never allocate");
        axi_write(4'h0, 32'h2);
        txn(1'b1, 4'h7, 1'b0, 1'b0);
        check({22'h0, seen}, {22'h0, exp_vec(1'b1, 4'hf, 1'b0, 1'b0)}, "force allocate");
        axi_write(4'h0, 32'h0);
        axi_read(4'h2);
        check({30'h0, resp}, 32'h2, "unmapped read");
    endtask
    task automatic test_modes;
        axi_write(4'h0, 32'h4);
        txn(1'b0, 4'hf, 1'b1, 1'b0);
        check({29'h0, extra}, {29'h0, 3'h5}, "exclusive hit invalidates");
        txn(1'b0, 4'hf, 1'b0, 1'b0);
        check({22'h0, seen}, {22'h0, exp_vec(1'b0, 4'h3, 1'b0, 1'b0)}, "exclusive miss");
        axi_write(4'h0, 32'h0);
        cap_master_model_i.set_shared(1'b1);
        txn(1'b0, 4'h2, 1'b1, 1'b0);
        check({22'h0, seen}, {22'h0, exp_vec(1'b0, 4'h6, 1'b1, 1'b0)}, "shared read");
        txn(1'b1, 4'h3, 1'b1, 1'b0);
        check({22'h0, seen}, {22'h0, exp_vec(1'b1, 4'h6, 1'b1, 1'b0)}, "shared write");
        axi_write(4'h0, 32'h8);
        txn(1'b0, 4'h2, 1'b1, 1'b0);
        check({22'h0, seen}, {22'h0, exp_vec(1'b0, 4'h2, 1'b1, 1'b0)}, "shared override");
        cap_master_model_i.set_shared(1'b0);
        axi_write(4'h0, 32'h0);
    endtask
    task automatic test_table;
        logic [31:0] base;
        axi_read(4'hc);
        base = rd;
        for (int f = 0; f < 2; f++) begin
            for (int i = 0; i < 20 * 2; i++) begin
                txn(i[0], legal[i / 4], i[1], f[0]);
                check({28'h0, seen[9:6]}, {22'h0, exp_vec(i[0], legal[i / 4], i[1], f[0])} >> 6,
                    "action");
                check({22'h0, seen}, {22'h0, exp_vec(i[0], legal[i / 4], i[1], f[0])},
                    "effects");
                check({29'h0, extra}, {29'h0, legal[i / 4][1] && |legal[i / 4][3:2],
                    exp_act(i[0], legal[i / 4], i[1]) inside {CAP_SB_L2_DIRTY, CAP_SB_L2_L3,
                    CAP_SB_ALLOC, CAP_SB_ALLOC_L3}, 1'b0}, "lookup");
            end
        end
        axi_read(4'hc);
        check(rd, base + 32'h50, "transaction count");
        axi_read(4'h8);
        check(rd, {20'h0, 4'he, 4'(CAP_SB_L2_DIRTY), 4'hf}, "last decision");
        axi_read(4'h4);
        check(rd, 32'h0, "undefined count");
    endtask
    initial begin
        aresetn = 1'b0;
        s_awaddr = 4'h0;
        s_awvalid = 1'b0;
        s_wdata = 32'h0;
        s_wstrb = 4'hf;
        s_wvalid = 1'b0;
        s_bready = 1'b0;
        s_araddr = 4'h0;
        s_arvalid = 1'b0;
        s_rready = 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        test_regs();
        test_modes();
        test_table();
        wrap_up();
    end
    initial begin
        #20000;
        $display("Error at %0t: watchdog expired", $time);
        failures++;
        wrap_up();
    end
endmodule
bind cap_policy cap_policy_assertions cap_policy_assertions_i (.aclk, .aresetn, .txn_valid,
    .txn_write, .txn_cache, .txn_burst, .txn_hit, .pol_valid, .pol_action, .pol_l3_access,
    .pol_allocate, .pol_dirty, .pol_buffer, .pol_merge_ok, .pol_drain_now);
